// >>> src/modbus_rtu_slave_engine.sv
// RTU slave command interpreter: frames bytes from the UART, decodes
// functions, accesses the register side and streams the reply back.
// Assumes UART and register side run on core_clk; no synchronisers needed.
`timescale 1ns/100ps
module modbus_rtu_slave_engine #(
  parameter int BUSY_CYCLES = modbus_pkg::BUSY_CYCLES,
  parameter int MS_CYCLES = modbus_pkg::MS_CYCLES,
  parameter int T35_CYCLES = modbus_pkg::T35_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] slave_addr,
  input wire logic write_enable,
  input wire logic [7:0] eoq_delay_ms,
  input wire logic [7:0] resp_delay_ms,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic reg_req,
  output logic reg_we,
  output logic [1:0] reg_kind,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_bad,
  input wire logic reg_protected,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata
);
  modbus_pkg::state_t st_q;
  logic [31:0] busy_cnt_q;
  logic busy_q;
  logic [31:0] gap_q;
  logic [31:0] dly_q;
  logic [7:0] len_q;
  logic [7:0] hdr_q [0:6];
  logic [6:0] i_q;
  logic [6:0] cnt_q;
  logic [7:0] exc_q;
  logic exc_flag_q;
  logic [7:0] acc_q;
  logic [7:0] lo_q;
  logic [7:0] wd_hi_q;
  logic [7:0] tx_idx_q;
  logic [7:0] tx_len_q;
  logic [7:0] rbc_q;
  logic [15:0] crc;
  logic [7:0] rd_data;
  logic mem_we;
  logic [7:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_raddr;
  logic crc_clr;
  logic crc_en;
  logic [7:0] crc_data;
  logic [7:0] tx_byte;

  // ----------------------------------------------------------------
  // Decode of the captured header
  // ----------------------------------------------------------------
  logic [7:0] fn;
  logic [15:0] qty;
  logic [7:0] bc;
  logic bit_rd, reg_rd, is_rd, fn_known, value_ok, last, byte_full;
  logic [31:0] gap_target;
  logic [31:0] dly_target;
  logic frame_end;

  assign fn = hdr_q[1];
  assign qty = {hdr_q[4], hdr_q[5]};
  assign bc = hdr_q[6];
  assign bit_rd = (fn == modbus_pkg::FN_RD_COILS) || (fn == modbus_pkg::FN_RD_INPUTS);
  assign reg_rd = (fn == modbus_pkg::FN_RD_HOLD) || (fn == modbus_pkg::FN_RD_INREG);
  assign is_rd = bit_rd || reg_rd;
  assign fn_known = is_rd || (fn == modbus_pkg::FN_WR_COIL) || (fn == modbus_pkg::FN_WR_REG) ||
                    (fn == modbus_pkg::FN_WR_COILS) || (fn == modbus_pkg::FN_WR_REGS);
  assign last = (i_q == cnt_q - 7'h01);
  assign byte_full = (i_q[2:0] == 3'h7) || last;
  assign gap_target = 32'(T35_CYCLES) + 32'(eoq_delay_ms) * 32'(MS_CYCLES);
  assign dly_target = 32'(resp_delay_ms) * 32'(MS_CYCLES);
  assign frame_end = (st_q == modbus_pkg::S_RX) && (len_q != 8'h00) && !rx_valid &&
                     (gap_q >= gap_target);

  always_comb begin
    value_ok = 1'b0;
    unique case (fn)
      modbus_pkg::FN_RD_COILS, modbus_pkg::FN_RD_INPUTS: begin
        value_ok = (qty != 16'h0000) && (qty <= modbus_pkg::MAX_BITS) && (len_q == modbus_pkg::FIXED_LEN);
      end
      modbus_pkg::FN_RD_HOLD, modbus_pkg::FN_RD_INREG: begin
        value_ok = (qty != 16'h0000) && (qty <= modbus_pkg::MAX_REGS) && (len_q == modbus_pkg::FIXED_LEN);
      end
      modbus_pkg::FN_WR_COIL: begin
        value_ok = ((qty == modbus_pkg::COIL_ON) || (qty == modbus_pkg::COIL_OFF)) &&
                   (len_q == modbus_pkg::FIXED_LEN);
      end
      modbus_pkg::FN_WR_REG: begin
        value_ok = (len_q == modbus_pkg::FIXED_LEN);
      end
      modbus_pkg::FN_WR_COILS: begin
        value_ok = (qty != 16'h0000) && (qty <= modbus_pkg::MAX_BITS) &&
                   ({8'h00, bc} == ((qty + 16'h0007) >> 3)) &&
                   (len_q == bc + modbus_pkg::HDR_LEN + 8'h02);
      end
      modbus_pkg::FN_WR_REGS: begin
        value_ok = (qty != 16'h0000) && (qty <= modbus_pkg::MAX_REGS) && ({8'h00, bc} == (qty << 1)) &&
                   (len_q == bc + modbus_pkg::HDR_LEN + 8'h02);
      end
      default: value_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Busy window after reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 32'h00000000;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (busy_cnt_q == 32'(BUSY_CYCLES - 1)) begin
        busy_q <= 1'b0;
      end
      busy_cnt_q <= busy_cnt_q + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Line silence and response delay timers
  // ----------------------------------------------------------------
  // Saturates so a long idle line cannot wrap and fake a short gap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 32'h00000000;
    end else if (rx_valid) begin
      gap_q <= 32'h00000000;
    end else if (gap_q != 32'hFFFFFFFF) begin
      gap_q <= gap_q + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dly_q <= 32'h00000000;
    end else if (st_q == modbus_pkg::S_DELAY) begin
      dly_q <= dly_q + 32'h00000001;
    end else begin
      dly_q <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Frame store and CRC
  // ----------------------------------------------------------------
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = len_q;
    mem_wdata = rx_data;
    if (st_q == modbus_pkg::S_RX) begin
      mem_we = rx_valid;
    end else if (st_q == modbus_pkg::S_REQ && reg_ack && bit_rd && byte_full) begin
      mem_we = 1'b1;
      mem_waddr = modbus_pkg::RESP_BASE + {4'h0, i_q[6:3]};
      mem_wdata = acc_q | (8'(reg_rdata[0]) << i_q[2:0]);
    end else if (st_q == modbus_pkg::S_REQ && reg_ack && reg_rd) begin
      mem_we = 1'b1;
      mem_waddr = modbus_pkg::RESP_BASE + {i_q, 1'b0};
      mem_wdata = reg_rdata[15:8];
    end else if (st_q == modbus_pkg::S_LO) begin
      mem_we = 1'b1;
      mem_waddr = modbus_pkg::RESP_BASE + {i_q, 1'b1};
      mem_wdata = lo_q;
    end
  end

  always_comb begin
    mem_raddr = modbus_pkg::RESP_BASE + tx_idx_q - 8'h03;
    if (st_q == modbus_pkg::S_FETCH1) begin
      mem_raddr = (fn == modbus_pkg::FN_WR_COILS) ? modbus_pkg::HDR_LEN + {4'h0, i_q[6:3]}
                                                  : modbus_pkg::HDR_LEN + {i_q, 1'b0};
    end else if (st_q == modbus_pkg::S_FETCH2) begin
      mem_raddr = modbus_pkg::HDR_LEN + {i_q, 1'b1};
    end
  end

  frame_ram #(.WIDTH(8), .AW(8)) u_ram (
    .core_clk(core_clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(rd_data)
  );

  // Reply byte for the current index: header, payload, then CRC low/high
  always_comb begin
    tx_byte = rd_data;
    if (tx_idx_q == tx_len_q) begin
      tx_byte = crc[7:0];
    end else if (tx_idx_q == tx_len_q + 8'h01) begin
      tx_byte = crc[15:8];
    end else if (tx_idx_q == 8'h00) begin
      tx_byte = hdr_q[0];
    end else if (tx_idx_q == 8'h01) begin
      tx_byte = exc_flag_q ? (fn | modbus_pkg::EX_FLAG) : fn;
    end else if (exc_flag_q) begin
      tx_byte = exc_q;
    end else if (is_rd && tx_idx_q == 8'h02) begin
      tx_byte = rbc_q;
    end else if (!is_rd) begin
      tx_byte = hdr_q[tx_idx_q[2:0]];
    end
  end

  assign crc_clr = (st_q == modbus_pkg::S_DELAY) || (st_q == modbus_pkg::S_RX && len_q == 8'h00 && !rx_valid);
  assign crc_en = ((st_q == modbus_pkg::S_RX) && rx_valid) ||
                  ((st_q == modbus_pkg::S_TX_BYTE) && (tx_idx_q < tx_len_q));
  assign crc_data = (st_q == modbus_pkg::S_RX) ? rx_data : tx_byte;

  crc16_rtu u_crc (
    .core_clk(core_clk),
    .rst(rst),
    .clr(crc_clr),
    .en(crc_en),
    .data(crc_data),
    .crc(crc)
  );

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  assign reg_req = (st_q == modbus_pkg::S_REQ);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= modbus_pkg::S_RX;
      len_q <= 8'h00;
      for (int k = 0; k < 7; k++) begin
        hdr_q[k] <= 8'h00;
      end
      i_q <= 7'h00;
      cnt_q <= 7'h00;
      exc_q <= 8'h00;
      exc_flag_q <= 1'b0;
      acc_q <= 8'h00;
      lo_q <= 8'h00;
      wd_hi_q <= 8'h00;
      tx_idx_q <= 8'h00;
      tx_len_q <= 8'h00;
      rbc_q <= 8'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      reg_we <= 1'b0;
      reg_kind <= modbus_pkg::KIND_COIL;
      reg_addr <= 16'h0000;
      reg_wdata <= 16'h0000;
    end else begin
      unique case (st_q)
        modbus_pkg::S_RX: begin
          if (rx_valid) begin
            if (len_q < modbus_pkg::HDR_LEN) begin
              hdr_q[len_q[2:0]] <= rx_data;
            end
            if (len_q != 8'hFF) begin
              len_q <= len_q + 8'h01;
            end
          end else if (frame_end) begin
            st_q <= modbus_pkg::S_CHECK;
          end
        end
        modbus_pkg::S_CHECK: begin
          exc_flag_q <= 1'b1;
          i_q <= 7'h00;
          acc_q <= 8'h00;
          cnt_q <= (fn == modbus_pkg::FN_WR_COIL || fn == modbus_pkg::FN_WR_REG) ? 7'h01 : qty[6:0];
          reg_addr <= {hdr_q[2], hdr_q[3]};
          reg_wdata <= (fn == modbus_pkg::FN_WR_COIL) ? {15'h0000, qty == modbus_pkg::COIL_ON} : qty;
          reg_we <= !is_rd;
          rbc_q <= bit_rd ? 8'((qty + 16'h0007) >> 3) : 8'(qty << 1);
          reg_kind <= (fn == modbus_pkg::FN_RD_INPUTS) ? modbus_pkg::KIND_INPUT :
                      (fn == modbus_pkg::FN_RD_INREG) ? modbus_pkg::KIND_INREG :
                      (fn == modbus_pkg::FN_RD_HOLD || fn == modbus_pkg::FN_WR_REG ||
                       fn == modbus_pkg::FN_WR_REGS) ? modbus_pkg::KIND_HOLD : modbus_pkg::KIND_COIL;
          if (len_q < modbus_pkg::FIXED_LEN || crc != 16'h0000 || hdr_q[0] != slave_addr) begin
            len_q <= 8'h00;
          end else if (busy_q) begin
            exc_q <= modbus_pkg::EX_BUSY;
            st_q <= modbus_pkg::S_DELAY;
          end else if (!fn_known) begin
            exc_q <= modbus_pkg::EX_ILL_FUNC;
            st_q <= modbus_pkg::S_DELAY;
          end else if (!value_ok) begin
            exc_q <= modbus_pkg::EX_ILL_VALUE;
            st_q <= modbus_pkg::S_DELAY;
          end else begin
            exc_flag_q <= 1'b0;
            st_q <= modbus_pkg::S_PRE;
          end
          if (len_q < modbus_pkg::FIXED_LEN || crc != 16'h0000 || hdr_q[0] != slave_addr) begin
            st_q <= modbus_pkg::S_RX;
          end
        end
        // Every address is vetted before the first write, so a refused
        // multi-item command leaves nothing half written
        modbus_pkg::S_PRE: begin
          if (reg_bad) begin
            exc_flag_q <= 1'b1;
            exc_q <= modbus_pkg::EX_ILL_ADDR;
            st_q <= modbus_pkg::S_DELAY;
          end else if (reg_we && reg_protected && !write_enable) begin
            exc_flag_q <= 1'b1;
            exc_q <= modbus_pkg::EX_NAK;
            st_q <= modbus_pkg::S_DELAY;
          end else if (last) begin
            i_q <= 7'h00;
            reg_addr <= {hdr_q[2], hdr_q[3]};
            st_q <= (fn == modbus_pkg::FN_WR_COILS || fn == modbus_pkg::FN_WR_REGS) ?
                    modbus_pkg::S_FETCH1 : modbus_pkg::S_REQ;
          end else begin
            i_q <= i_q + 7'h01;
            reg_addr <= reg_addr + 16'h0001;
          end
        end
        modbus_pkg::S_FETCH1: st_q <= modbus_pkg::S_FETCH2;
        modbus_pkg::S_FETCH2: begin
          wd_hi_q <= rd_data;
          st_q <= modbus_pkg::S_FETCH3;
        end
        modbus_pkg::S_FETCH3: begin
          reg_wdata <= (fn == modbus_pkg::FN_WR_COILS) ? {15'h0000, wd_hi_q[i_q[2:0]]}
                                                       : {wd_hi_q, rd_data};
          st_q <= modbus_pkg::S_REQ;
        end
        modbus_pkg::S_REQ, modbus_pkg::S_LO: begin
          if (st_q == modbus_pkg::S_REQ && reg_ack && bit_rd) begin
            acc_q <= byte_full ? 8'h00 : (acc_q | (8'(reg_rdata[0]) << i_q[2:0]));
          end
          if (st_q == modbus_pkg::S_REQ && reg_ack && reg_rd) begin
            lo_q <= reg_rdata[7:0];
            st_q <= modbus_pkg::S_LO;
          end else if (st_q == modbus_pkg::S_LO || reg_ack) begin
            if (last) begin
              st_q <= modbus_pkg::S_DELAY;
            end else begin
              i_q <= i_q + 7'h01;
              reg_addr <= reg_addr + 16'h0001;
              st_q <= (fn == modbus_pkg::FN_WR_COILS || fn == modbus_pkg::FN_WR_REGS) ?
                      modbus_pkg::S_FETCH1 : modbus_pkg::S_REQ;
            end
          end
        end
        modbus_pkg::S_DELAY: begin
          tx_idx_q <= 8'h00;
          tx_len_q <= exc_flag_q ? 8'h03 : (is_rd ? rbc_q + 8'h03 : 8'h06);
          if (dly_q >= dly_target) begin
            st_q <= modbus_pkg::S_TX_ADDR;
          end
        end
        modbus_pkg::S_TX_ADDR: st_q <= modbus_pkg::S_TX_BYTE;
        modbus_pkg::S_TX_BYTE: begin
          tx_data <= tx_byte;
          tx_valid <= 1'b1;
          st_q <= modbus_pkg::S_TX_WAIT;
        end
        modbus_pkg::S_TX_WAIT: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (tx_idx_q == tx_len_q + 8'h01) begin
              len_q <= 8'h00;
              st_q <= modbus_pkg::S_RX;
            end else begin
              tx_idx_q <= tx_idx_q + 8'h01;
              st_q <= modbus_pkg::S_TX_ADDR;
            end
          end
        end
      endcase
    end
  end
endmodule // modbus_rtu_slave_engine

// >>> src/modbus_pkg.sv
// Constants shared by the RTU slave engine and its helpers.
// Assumes a 200 MHz core clock; timing counts are derived from it here.
package modbus_pkg;
  // ----------------------------------------------------------------
  // Function and exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FN_RD_COILS = 8'h01;
  localparam logic [7:0] FN_RD_INPUTS = 8'h02;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_INREG = 8'h04;
  localparam logic [7:0] FN_WR_COIL = 8'h05;
  localparam logic [7:0] FN_WR_REG = 8'h06;
  localparam logic [7:0] FN_WR_COILS = 8'h0F;
  localparam logic [7:0] FN_WR_REGS = 8'h10;
  localparam logic [7:0] EX_ILL_FUNC = 8'h01;
  localparam logic [7:0] EX_ILL_ADDR = 8'h02;
  localparam logic [7:0] EX_ILL_VALUE = 8'h03;
  localparam logic [7:0] EX_BUSY = 8'h06;
  localparam logic [7:0] EX_NAK = 8'h07;
  localparam logic [7:0] EX_FLAG = 8'h80;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // ----------------------------------------------------------------
  // Register space selector and frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_COIL = 2'h0;
  localparam logic [1:0] KIND_INPUT = 2'h1;
  localparam logic [1:0] KIND_HOLD = 2'h2;
  localparam logic [1:0] KIND_INREG = 2'h3;
  localparam logic [15:0] MAX_BITS = 16'h0040;
  localparam logic [15:0] MAX_REGS = 16'h003E;
  localparam logic [7:0] HDR_LEN = 8'h07;
  localparam logic [7:0] FIXED_LEN = 8'h08;
  localparam logic [7:0] RESP_BASE = 8'h80;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int BUSY_MS = 3000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int BUSY_CYCLES = BUSY_MS * MS_CYCLES;
  localparam int BAUD = 9600;
  localparam int CHAR_BITS = 11;
  // Silence of 3.5 characters, rounded up to whole cycles
  localparam int T35_CYCLES = ((CLK_HZ / 100) * CHAR_BITS * 35 + BAUD / 10 - 1) / (BAUD / 10);

  typedef enum logic [3:0] {
    S_RX, S_CHECK, S_PRE, S_FETCH1, S_FETCH2, S_FETCH3, S_REQ, S_LO,
    S_DELAY, S_TX_ADDR, S_TX_BYTE, S_TX_WAIT
  } state_t;
endpackage

// >>> src/frame_ram.sv
// Byte store for received frames and assembled reply data.
// One write port and one read port; read data is registered.
`timescale 1ns/100ps
module frame_ram #(
  parameter int WIDTH = 8,
  parameter int AW = 8
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // frame_ram

// >>> src/crc16_rtu.sv
// Running CRC-16 over a byte stream, reflected polynomial, one byte a cycle.
// A frame followed by its own CRC (low byte first) leaves a residue of zero.
`timescale 1ns/100ps
module crc16_rtu (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ modbus_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crc <= modbus_pkg::CRC_INIT;
    end else if (clr) begin
      crc <= modbus_pkg::CRC_INIT;
    end else if (en) begin
      crc <= step(crc, data);
    end
  end
endmodule // crc16_rtu

// >>> testbench/modbus_rtu_slave_engine_checker.sv
// Port assertions for the RTU slave engine.
// Bound into the engine; one clock domain, core_clk with async rst.
`timescale 1ns/100ps
module rtu_engine_checker #(
  parameter int BUSY_CYCLES = 50,
  parameter int MS_CYCLES = 10,
  parameter int T35_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] slave_addr,
  input wire logic write_enable,
  input wire logic [7:0] eoq_delay_ms,
  input wire logic [7:0] resp_delay_ms,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [1:0] reg_kind,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_bad,
  input wire logic reg_protected,
  input wire logic reg_ack
);
  // -------------------------------------------
  // Helper counters
  // -------------------------------------------
  int gap_q;
  int up_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) gap_q <= 0;
    else if (rx_valid) gap_q <= 0;
    else gap_q <= gap_q + 1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) up_q <= 0;
    else if (up_q < BUSY_CYCLES) up_q <= up_q + 1;
  end
  // -------------------------------------------
  // Properties
  // -------------------------------------------
  sequence s_accept;
    tx_valid && tx_ready;
  endsequence
  sequence s_quiet;
    !tx_valid [*3];
  endsequence
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  property p_next_gap;
    s_accept |=> !tx_valid [*2];
  endproperty
  property p_first_addr;
    s_quiet ##1 tx_valid |-> tx_data == slave_addr;
  endproperty
  property p_req_hold;
    reg_req && !reg_ack |=> reg_req && $stable({reg_we, reg_kind, reg_addr, reg_wdata});
  endproperty
  property p_silence;
    $rose(tx_valid) |-> gap_q >= T35_CYCLES + (int'(eoq_delay_ms) + int'(resp_delay_ms)) * MS_CYCLES;
  endproperty
  property p_busy;
    up_q < BUSY_CYCLES |-> !reg_req;
  endproperty
  property p_protect;
    reg_req && reg_we |-> !(reg_protected && !write_enable);
  endproperty
  property p_bad;
    reg_req |-> !reg_bad;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte changed before acceptance");
  a_next_gap: assert property (p_next_gap) else $error("next reply byte too early");
  a_first_addr: assert property (p_first_addr) else $error("reply does not start with address");
  a_req_hold: assert property (p_req_hold) else $error("register request changed before ack");
  a_silence: assert property (p_silence) else $error("reply before silence and delay");
  a_busy: assert property (p_busy) else $error("register access in busy window");
  a_protect: assert property (p_protect) else $error("protected write without enable");
  a_bad: assert property (p_bad) else $error("access to unsupported address");
endmodule // rtu_engine_checker

bind modbus_rtu_slave_engine rtu_engine_checker #(.BUSY_CYCLES(BUSY_CYCLES), .MS_CYCLES(MS_CYCLES),
  .T35_CYCLES(T35_CYCLES)) i_rtu_engine_checker (.core_clk, .rst, .slave_addr, .write_enable,
  .eoq_delay_ms, .resp_delay_ms, .rx_valid, .tx_valid, .tx_data, .tx_ready, .reg_req, .reg_we,
  .reg_kind, .reg_addr, .reg_wdata, .reg_bad, .reg_protected, .reg_ack);

// >>> testbench/rtu_host_model.sv
// Host master model: sends framed requests, collects reply bytes.
// Assumes the engine's one-cycle receive strobe and valid/ready transmit side.
`timescale 1ns/100ps
module rtu_host_model (
  input wire logic core_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [7:0] got[$];
  logic slow = 1'b0;
  int tick = 0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // Slow mode accepts only every third cycle to stall the reply
  always @(posedge core_clk) begin
    tick <= tick + 1;
    tx_ready <= !slow || (tick % 3 == 0);
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ modbus_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  // Idle data line shows the inverse of the last byte, never a stale copy
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= f[i];
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_data <= ~f[i];
    end
  endtask
endmodule // rtu_host_model

// >>> testbench/tb_modbus_rtu_slave_engine.sv
// Self-checking bench for the RTU slave engine.
// Host model on the serial side; register side modelled here, ack one cycle late.
`timescale 1ns/100ps
module tb_modbus_rtu_slave_engine;
  localparam logic [7:0] SA = 8'h11;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic write_enable = 1'b0;
  logic rx_valid, tx_valid, tx_ready, reg_req, reg_we, reg_bad, reg_protected, reg_ack;
  logic [7:0] rx_data, tx_data;
  logic [1:0] reg_kind;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] mem [4][256];
  logic ack_q = 1'b0;
  logic [7:0] f[$];
  logic [7:0] e[$];
  int err_total = 0;
  int samples_checked = 0;
  always #2.5 core_clk = ~core_clk;
  modbus_rtu_slave_engine #(.BUSY_CYCLES(60), .MS_CYCLES(10), .T35_CYCLES(20)) i_modbus_rtu_slave_engine (
    .core_clk, .rst, .slave_addr(SA), .write_enable, .eoq_delay_ms(8'h01), .resp_delay_ms(8'h01),
    .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready, .reg_req, .reg_we, .reg_kind, .reg_addr,
    .reg_wdata, .reg_bad, .reg_protected, .reg_ack, .reg_rdata);
  rtu_host_model i_rtu_host_model (.core_clk, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data);
  // -------------------------------------------
  // Register side: only the low 256 addresses exist, 0x50 is protected
  // -------------------------------------------
  assign reg_bad = reg_addr[15:8] != 8'h00;
  assign reg_protected = reg_addr[7:0] == 8'h50;
  assign reg_ack = ack_q;
  assign reg_rdata = mem[reg_kind][reg_addr[7:0]];
  initial foreach (mem[k, a]) mem[k][a] = {4'(k), 4'hA, 8'(a)} ^ {15'h0000, a[1]};
  always @(posedge core_clk) begin
    ack_q <= reg_req && !ack_q;
    if (reg_req && reg_ack && reg_we) mem[reg_kind][reg_addr[7:0]] <= reg_wdata;
  end
  // -------------------------------------------
  // Shared tasks
  // -------------------------------------------
  task automatic fail(input string msg);
    err_total++;
    $display("ERROR %0t: %s", $time, msg);
  endtask
  task automatic req(input logic [7:0] fn, input logic [15:0] a, input logic [15:0] b);
    f = {SA, fn, a[15:8], a[7:0], b[15:8], b[7:0]};
  endtask
  // Empty e means the frame must be ignored
  task automatic xact(input logic bad);
    logic [15:0] c;
    if (e.size() != 0) begin
      c = i_rtu_host_model.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    i_rtu_host_model.got.delete();
    i_rtu_host_model.send(f, bad);
    for (int n = 0; n < 3000 && (n < 400 || i_rtu_host_model.got.size() < e.size()); n++) @(posedge core_clk);
    samples_checked++;
    if (i_rtu_host_model.got.size() != e.size()) fail("reply length");
    else foreach (e[i]) begin
      samples_checked++;
      if (i_rtu_host_model.got[i] !== e[i]) fail("reply byte");
    end
  endtask
  // -------------------------------------------
  // Scenarios
  // -------------------------------------------
  task automatic t_read();
    logic [15:0] b;
    for (int k = 0; k < 4; k++) begin
      i_rtu_host_model.slow = (k == 3);
      b = 16'h0000;
      for (int i = 0; i < 10; i++) b[i] = mem[k][3 + i][0];
      req(8'(k + 1), 16'h0003, k < 2 ? 16'h000A : 16'h0002);
      if (k < 2) e = {SA, 8'(k + 1), 8'h02, b[7:0], b[15:8]};
      else e = {SA, 8'(k + 1), 8'h04, mem[k][3][15:8], mem[k][3][7:0], mem[k][4][15:8], mem[k][4][7:0]};
      xact(1'b0);
    end
    i_rtu_host_model.slow = 1'b0;
    $display("t_read done");
  endtask
  task automatic t_write();
    for (int v = 1; v >= 0; v--) begin
      req(modbus_pkg::FN_WR_COIL, 16'h0007, v ? modbus_pkg::COIL_ON : modbus_pkg::COIL_OFF);
      e = f;
      xact(1'b0);
      samples_checked++;
      if (mem[0][7][0] !== 1'(v)) fail("coil force");
    end
    req(modbus_pkg::FN_WR_REG, 16'h0009, 16'h1234);
    e = f;
    xact(1'b0);
    f = {SA, modbus_pkg::FN_WR_COILS, 8'h00, 8'h10, 8'h00, 8'h0A, 8'h02, 8'hA5, 8'h02};
    e = f[0:5];
    xact(1'b0);
    for (int i = 0; i < 10; i++) if (mem[0][16 + i][0] !== (10'h2A5 >> i & 1'b1)) fail("coil bits");
    f = {SA, modbus_pkg::FN_WR_REGS, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'h13, 8'h57, 8'h9B, 8'hDF};
    e = f[0:5];
    xact(1'b0);
    samples_checked++;
    if (mem[2][9] !== 16'h1234 || mem[2][32] !== 16'h1357 || mem[2][33] !== 16'h9BDF) fail("reg write");
    $display("t_write done");
  endtask
  task automatic t_errors();
    req(8'h07, 16'h0000, 16'h0001);
    e = {SA, 8'h87, modbus_pkg::EX_ILL_FUNC};
    xact(1'b0);
    req(modbus_pkg::FN_RD_COILS, 16'h0000, 16'h0041);
    e = {SA, 8'h81, modbus_pkg::EX_ILL_VALUE};
    xact(1'b0);
    req(modbus_pkg::FN_RD_HOLD, 16'h0200, 16'h0001);
    e = {SA, 8'h83, modbus_pkg::EX_ILL_ADDR};
    xact(1'b0);
    req(modbus_pkg::FN_WR_REG, 16'h0050, 16'hBEEF);
    e = {SA, 8'h86, modbus_pkg::EX_NAK};
    xact(1'b0);
    samples_checked++;
    if (mem[2][80] === 16'hBEEF) fail("protected write landed");
    @(posedge core_clk);
    write_enable <= 1'b1;
    e = f;
    xact(1'b0);
    samples_checked++;
    if (mem[2][80] !== 16'hBEEF) fail("enabled write lost");
    @(posedge core_clk);
    write_enable <= 1'b0;
    e = {};
    xact(1'b1);
    f[0] = SA + 8'h01;
    xact(1'b0);
    $display("t_errors done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    samples_checked++;
    if (tx_valid !== 1'b0 || reg_req !== 1'b0) fail("reset outputs");
    req(modbus_pkg::FN_RD_HOLD, 16'h0000, 16'h0001);
    e = {SA, 8'h83, modbus_pkg::EX_BUSY};
    xact(1'b0);
    t_read();
    t_write();
    t_errors();
    report_and_stop();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end
endmodule // tb_modbus_rtu_slave_engine
